/* File: ptm_pkg.sv */
package ptm_pkg;

  localparam int NUM_TMR = 4;
  localparam int APB_AW  = 8;

  // Byte addresses of the register map
  localparam logic [7:0] OFS_CTRL_AL = 8'h00;
  localparam logic [7:0] OFS_CTRL_AH = 8'h04;
  localparam logic [7:0] OFS_CTRL_BL = 8'h08;
  localparam logic [7:0] OFS_CTRL_BH = 8'h0C;
  localparam logic [7:0] OFS_CNT_AL  = 8'h10;
  localparam logic [7:0] OFS_CNT_AH  = 8'h14;
  localparam logic [7:0] OFS_CNT_BL  = 8'h18;
  localparam logic [7:0] OFS_CNT_BH  = 8'h1C;
  localparam logic [7:0] OFS_PER_AL  = 8'h20;
  localparam logic [7:0] OFS_PER_AH  = 8'h24;
  localparam logic [7:0] OFS_PER_BL  = 8'h28;
  localparam logic [7:0] OFS_PER_BH  = 8'h2C;
  localparam logic [7:0] OFS_STAT    = 8'h30;
  localparam logic [7:0] OFS_MASK    = 8'h34;

  // Control register fields
  localparam int CTL_ON        = 15;
  localparam int CTL_IDLE_STOP = 13;
  localparam int CTL_SLEEP_RUN = 12;
  localparam int CTL_GATE      = 6;
  localparam int CTL_PS_HI     = 5;
  localparam int CTL_PS_LO     = 4;
  localparam int CTL_JOIN      = 3;
  localparam int CTL_EXT_CLK   = 1;

  localparam logic [15:0] CTL_LO_WMASK = 16'hB07A;
  localparam logic [15:0] CTL_HI_WMASK = 16'hB072;
  localparam logic [15:0] CTRL_RST     = 16'h0000;
  localparam logic [15:0] PERIOD_RST   = 16'hFFFF;
  localparam logic [15:0] CNT_RST      = 16'h0000;
  localparam logic [15:0] CNT_MAX      = 16'hFFFF;
  localparam logic [3:0]  STAT_RST     = 4'h0;
  localparam logic [3:0]  MASK_RST     = 4'h0;

  // Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
  localparam logic [7:0] PS_DIV1   = 8'h00;
  localparam logic [7:0] PS_DIV8   = 8'h07;
  localparam logic [7:0] PS_DIV64  = 8'h3F;
  localparam logic [7:0] PS_DIV256 = 8'hFF;

endpackage

/* File: ptm_sync.sv */
`timescale 1ns/10ps
module ptm_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] agree;

  assign agree = ~(s2_reg ^ s3_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      level  <= '0;
      rise   <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level  <= (agree & s2_reg) | (~agree & level);
      rise   <= agree & s2_reg & ~level;
    end
  end
endmodule

/* File: ptm_pair.sv */
`timescale 1ns/10ps
module ptm_pair (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        join_en,
  input  wire logic        tick_lo,
  input  wire logic        tick_hi,
  input  wire logic [15:0] per_lo,
  input  wire logic [15:0] per_hi,
  input  wire logic        load_lo,
  input  wire logic        load_hi,
  input  wire logic [15:0] load_data,
  output logic      [15:0] cnt_lo,
  output logic      [15:0] cnt_hi,
  output logic             match_lo,
  output logic             match_hi
);
  import ptm_pkg::*;

  logic hit_lo;
  logic hit_hi;
  logic hit_32;
  logic carry;

  assign hit_lo = cnt_lo == per_lo;
  assign hit_hi = cnt_hi == per_hi;
  assign hit_32 = hit_lo & hit_hi;
  assign carry  = cnt_lo == CNT_MAX;

  // Joined pair signals only on the high slot
  assign match_lo = ~join_en & tick_lo & hit_lo;
  assign match_hi = join_en ? (tick_lo & hit_32) : (tick_hi & hit_hi); // RULE_05 RULE_12

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_lo <= CNT_RST;
    end else if (load_lo) begin
      cnt_lo <= load_data;
    end else if (tick_lo) begin
      if (join_en ? hit_32 : hit_lo) begin
        cnt_lo <= CNT_RST; // RULE_14
      end else begin
        cnt_lo <= cnt_lo + 16'h0001; // RULE_09
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_hi <= CNT_RST;
    end else if (load_hi) begin
      cnt_hi <= load_data;
    end else if (join_en) begin
      if (tick_lo && hit_32) begin
        cnt_hi <= CNT_RST; // RULE_14
      end else if (tick_lo && carry) begin
        cnt_hi <= cnt_hi + 16'h0001; // RULE_13 RULE_09
      end
    end else if (tick_hi) begin
      if (hit_hi) begin
        cnt_hi <= CNT_RST; // RULE_14
      end else begin
        cnt_hi <= cnt_hi + 16'h0001; // RULE_04
      end
    end
  end
endmodule

/* File: ptm_timers.sv */
// Overview of operation
// (RULE_01) Four 16-bit timers, two joinable pairs
// (RULE_02) Split pair: all synchronous 16-bit modes
// (RULE_03) Joined pair: 32-bit timer or synchronous counter
// (RULE_04) Each timer: synchronous timer or counter
// (RULE_05) Interrupt on full 32-bit period match
// (RULE_06) Gating, prescaler, run in idle/sleep
// (RULE_07) Event trigger only from first pair
// (RULE_08) Only first pair serves as time base
// (RULE_09) Low timer low half, high timer high
// (RULE_10) Joined: high control bits ignored
// (RULE_11) Joined: low clock and gate drive pair
// (RULE_12) Joined: high timer flag signals match
// (RULE_13) High half advances on low carry
// (RULE_14) Period match restarts count from zero
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/10ps
module ptm_timers (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic [ptm_pkg::APB_AW-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [3:0]                 ext_clk,
  input  wire logic [3:0]                 gate_in,
  input  wire logic                       idle_mode,
  input  wire logic                       sleep_mode,
  input  wire logic                       tb_sel,
  output logic      [15:0]                tb_count,
  output logic                            tb_tick,
  output logic                            trig_out,
  output logic                            irq
);
  import ptm_pkg::*;

  logic [15:0] ctrl_reg   [NUM_TMR];
  logic [15:0] period_reg [NUM_TMR];
  logic [7:0]  ps_reg     [NUM_TMR];
  logic [15:0] cnt        [NUM_TMR];
  logic [3:0]  stat_reg;
  logic [3:0]  mask_reg;
  logic [3:0]  stat_next;
  logic [3:0]  match;
  logic [3:0]  run;
  logic [3:0]  evt;
  logic [3:0]  tick;
  logic [3:0]  load;
  logic [3:0]  ext_rise;
  logic [3:0]  gate_lvl;
  logic [1:0]  join_en;
  logic        wr_en;
  logic        rd_setup;
  logic [31:0] rdata_next;
  logic        sel_ctrl;
  logic        sel_cnt;
  logic        sel_per;
  logic        sel_stat;
  logic        sel_mask;
  logic        tb_src_tick;

  // Address decoders for the APB paths; prescaler limit lookup
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'b00) && (a <= OFS_MASK);
  endfunction

  function automatic logic [1:0] tmr_index(input logic [7:0] a);
    tmr_index = a[3:2];
  endfunction

  function automatic logic group_hit(input logic [7:0] a, input logic [7:0] base);
    group_hit = a[7:4] == base[7:4];
  endfunction

  function automatic logic [7:0] ps_limit(input logic [1:0] sel);
    case (sel)
      2'b00:   ps_limit = PS_DIV1;
      2'b01:   ps_limit = PS_DIV8;
      2'b10:   ps_limit = PS_DIV64;
      default: ps_limit = PS_DIV256;
    endcase
  endfunction

  // APB slave: zero wait states
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~is_mapped(paddr);
  assign wr_en    = psel & penable & pwrite & is_mapped(paddr);
  assign rd_setup = psel & ~penable & ~pwrite;

  // Register group selects
  assign sel_ctrl = group_hit(paddr, OFS_CTRL_AL);
  assign sel_cnt  = group_hit(paddr, OFS_CNT_AL);
  assign sel_per  = group_hit(paddr, OFS_PER_AL);
  assign sel_stat = paddr == OFS_STAT;
  assign sel_mask = paddr == OFS_MASK;

  // Pin inputs through three-stage synchronisers
  ptm_sync #(
    .W(4)
  ) u_sync_gate (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (gate_in),
    .level (gate_lvl),
    .rise  ()
  );

  ptm_sync #(
    .W(4)
  ) u_sync_clk (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (ext_clk),
    .level (),
    .rise  (ext_rise)
  );

  // Control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_TMR; i++) begin
        ctrl_reg[i] <= CTRL_RST;
      end
    end else if (wr_en && sel_ctrl) begin
      if (paddr[2]) begin
        ctrl_reg[tmr_index(paddr)] <= pwdata[15:0] & CTL_HI_WMASK;
      end else begin
        ctrl_reg[tmr_index(paddr)] <= pwdata[15:0] & CTL_LO_WMASK;
      end
    end
  end

  // Period registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_TMR; i++) begin
        period_reg[i] <= PERIOD_RST;
      end
    end else if (wr_en && sel_per) begin
      period_reg[tmr_index(paddr)] <= pwdata[15:0];
    end
  end

  // Counter loads from software
  always_comb begin
    load = 4'h0;
    if (wr_en && sel_cnt) begin
      load[tmr_index(paddr)] = 1'b1;
    end
  end

  assign join_en[0] = ctrl_reg[0][CTL_JOIN]; // RULE_01
  assign join_en[1] = ctrl_reg[2][CTL_JOIN]; // RULE_01

  // Tick qualification per timer
  always_comb begin
    for (int i = 0; i < NUM_TMR; i++) begin
      run[i] = ctrl_reg[i][CTL_ON]
             & ~(idle_mode & ctrl_reg[i][CTL_IDLE_STOP])
             & ~(sleep_mode & ~ctrl_reg[i][CTL_SLEEP_RUN]); // RULE_06
      if (ctrl_reg[i][CTL_EXT_CLK]) begin
        evt[i] = ext_rise[i]; // RULE_02 RULE_03
      end else begin
        evt[i] = ~ctrl_reg[i][CTL_GATE] | gate_lvl[i]; // RULE_06
      end
      tick[i] = run[i] & evt[i]
              & (ps_reg[i] == ps_limit(ctrl_reg[i][CTL_PS_HI:CTL_PS_LO])); // RULE_06
    end
  end

  // Prescalers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_TMR; i++) begin
        ps_reg[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < NUM_TMR; i++) begin
        if (!run[i] || tick[i]) begin
          ps_reg[i] <= 8'h00;
        end else if (evt[i]) begin
          ps_reg[i] <= ps_reg[i] + 8'h01;
        end
      end
    end
  end

  // Timer pairs; a joined pair takes only the low tick
  ptm_pair u_pair_a (
    .clk       (clk),
    .rst_n     (rst_n),
    .join_en   (join_en[0]),
    .tick_lo   (tick[0]), // RULE_11
    .tick_hi   (tick[1] & ~join_en[0]), // RULE_10
    .per_lo    (period_reg[0]),
    .per_hi    (period_reg[1]),
    .load_lo   (load[0]),
    .load_hi   (load[1]),
    .load_data (pwdata[15:0]),
    .cnt_lo    (cnt[0]),
    .cnt_hi    (cnt[1]),
    .match_lo  (match[0]),
    .match_hi  (match[1])
  );

  ptm_pair u_pair_b (
    .clk       (clk),
    .rst_n     (rst_n),
    .join_en   (join_en[1]),
    .tick_lo   (tick[2]), // RULE_11
    .tick_hi   (tick[3] & ~join_en[1]), // RULE_10
    .per_lo    (period_reg[2]),
    .per_hi    (period_reg[3]),
    .load_lo   (load[2]),
    .load_hi   (load[3]),
    .load_data (pwdata[15:0]),
    .cnt_lo    (cnt[2]),
    .cnt_hi    (cnt[3]),
    .match_lo  (match[2]),
    .match_hi  (match[3])
  );

  // Status: match sets, write one clears, set wins
  always_comb begin
    stat_next = stat_reg;
    if (wr_en && sel_stat) begin
      stat_next = stat_next & ~pwdata[3:0];
    end
    stat_next = stat_next | match; // RULE_12
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= STAT_RST;
    end else begin
      stat_reg <= stat_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= MASK_RST;
    end else if (wr_en && sel_mask) begin
      mask_reg <= pwdata[3:0];
    end
  end

  assign irq = |(stat_reg & mask_reg); // RULE_05

  // Event trigger from the first pair only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_out <= 1'b0;
    end else begin
      trig_out <= match[1]; // RULE_07
    end
  end

  assign tb_src_tick = join_en[0] ? tick[0] : tick[1]; // RULE_08

  // Capture/compare time base from the first pair only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tb_count <= CNT_RST;
      tb_tick  <= 1'b0;
    end else if (tb_sel) begin
      tb_count <= cnt[1]; // RULE_08
      tb_tick  <= tb_src_tick;
    end else begin
      tb_count <= cnt[0]; // RULE_08
      tb_tick  <= tick[0];
    end
  end

  // Read data, captured in the setup phase
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (paddr[7:4])
      OFS_CTRL_AL[7:4]: rdata_next[15:0] = ctrl_reg[tmr_index(paddr)];
      OFS_CNT_AL[7:4]:  rdata_next[15:0] = cnt[tmr_index(paddr)];
      OFS_PER_AL[7:4]:  rdata_next[15:0] = period_reg[tmr_index(paddr)];
      OFS_STAT[7:4]: begin
        if (paddr == OFS_STAT) begin
          rdata_next[3:0] = stat_reg;
        end else if (paddr == OFS_MASK) begin
          rdata_next[3:0] = mask_reg;
        end
      end
      default: rdata_next = 32'h0000_0000;
    endcase
    if (!is_mapped(paddr)) begin
      rdata_next = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rdata_next;
    end
  end

endmodule

/* File: ptm_timers_properties.sv */
`timescale 1ns/10ps
module ptm_timers_properties
  import ptm_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [15:0]       tb_count,
  input wire logic              tb_tick,
  input wire logic              trig_out,
  input wire logic              irq
);
  logic mask_any;
  logic run_any;
  wire logic bad_a = (paddr > OFS_MASK) || (paddr[1:0] != 2'h0);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_mask_off;
    s_acc ##0 (pwrite && paddr == OFS_MASK && pwdata[3:0] == 4'h0);
  endsequence
  // Remember any unmask and any control or count write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_any <= 1'h0;
      run_any  <= 1'h0;
    end else if (psel && penable && pwrite && !bad_a) begin
      if (paddr == OFS_MASK && pwdata[3:0] != 4'h0) begin
        mask_any <= 1'h1;
      end
      if (paddr < OFS_PER_AL) begin
        run_any <= 1'h1;
      end
    end
  end
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_err_bad_addr: assert property (s_acc ##0 bad_a |-> pslverr)
    else $error("no error on unmapped address");
  a_err_good_addr: assert property (s_acc ##0 !bad_a |-> !pslverr)
    else $error("error on mapped address");
  a_rd_bad_zero: assert property (s_acc ##0 (!pwrite && bad_a) |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_rd_upper_zero: assert property (s_acc ##0 !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  a_rd_data_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  a_mask_off_irq: assert property (s_mask_off |=> !irq)
    else $error("irq with all masked");
  a_irq_needs_mask: assert property (!mask_any |-> !irq)
    else $error("irq before unmask");
  a_idle_quiet: assert property (!run_any |-> !trig_out && !tb_tick && tb_count == 16'h0)
    else $error("activity with timers off");
endmodule
bind ptm_timers ptm_timers_properties chk_u (
  .clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
  .pslverr, .tb_count, .tb_tick, .trig_out, .irq
);

/* File: paired_16_32_bit_timers_tb_top.sv */
`timescale 1ns/10ps
module paired_16_32_bit_timers_tb_top;
  import ptm_pkg::*;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  gate_in = 4'h0;
  logic        idle_mode = 1'h0;
  logic        tb_sel = 1'h0;
  logic [15:0] tb_count;
  logic        tb_tick;
  logic        trig_out;
  logic        irq;
  logic [3:0]  ext_clk = 4'h0;
  logic        sleep_mode = 1'h0;
  int          trig_cnt = 0;
  logic [31:0] seed = 32'hE8EE0DCB;
  logic [32:0] exq[$];
  int          miscompares = 0;
  int          num_checks = 0;
  ptm_timers dut_u (
    .clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .ext_clk, .gate_in, .idle_mode, .sleep_mode, .tb_sel,
    .tb_count, .tb_tick, .trig_out, .irq
  );
  always #5 clk = ~clk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic summarize();
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [32:0] e);
    if (!w) begin
      exq.push_back(e);
    end
    psel    <= 1'h1;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) begin
      @(posedge clk);
    end
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'h1, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb(a, 1'h0, 32'h0, e);
  endtask
  // Time base must stay within period and wrap to zero
  task automatic wrap(input logic [15:0] p);
    logic [15:0] prev;
    logic        hit;
    logic        prev_tick;
    hit = 1'h0;
    prev = tb_count;
    prev_tick = tb_tick;
    repeat (20) begin
      @(negedge clk);
      chk({32'h0, tb_count > p}, 33'h0);
      chk({32'h0, tb_count !== prev}, {32'h0, prev_tick});
      if (prev === p) begin
        chk({17'h0, tb_count}, 33'h0);
        hit = 1'h1;
      end
      prev = tb_count;
      prev_tick = tb_tick;
    end
    chk({32'h0, hit}, 33'h1);
    @(posedge clk);
  endtask
  // Random-width pulses on the pair B high clock pin
  task automatic pulses(input int n);
    logic [31:0] q;
    repeat (n) begin
      q = xs();
      ext_clk <= 4'h8;
      repeat (4 + q[1:0]) @(posedge clk);
      ext_clk <= 4'h0;
      repeat (4 + q[3:2]) @(posedge clk);
    end
  endtask
  // Read results checked against oldest expectation
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready) begin
      chk({pslverr, prdata}, (exq.size() > 0) ? exq.pop_front() : 33'hX);
    end
    if (trig_out === 1'h1) begin
      trig_cnt <= trig_cnt + 1;
    end
  end
  initial begin
    logic [31:0] r;
    int          trig_base;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    for (int i = 0; i < 14; i++) begin
      rd(8'(i * 4), (i >= 8 && i < 12) ? 33'hFFFF : 33'h0);
    end
    rd(8'h38, 33'h100000000);
    rd(8'h05, 33'h100000000);
    for (int k = 0; k < 4; k++) begin
      r = xs();
      wr(OFS_CTRL_AH, r);
      rd(OFS_CTRL_AH, {17'h0, r[15:0] & CTL_HI_WMASK});
      wr(OFS_PER_BH, r);
      rd(OFS_PER_BH, {17'h0, r[15:0]});
    end
    wr(OFS_CTRL_AH, 32'h0);
    wr(OFS_CNT_AH, 32'h0);
    wr(OFS_STAT, 32'hF);
    wr(OFS_PER_AL, 32'h2);
    wr(OFS_MASK, 32'h1);
    wr(OFS_CTRL_AL, 32'h8000);
    wrap(16'h2);
    chk({32'h0, irq}, 33'h1);
    wr(OFS_CTRL_AL, 32'h0);
    wr(OFS_MASK, 32'h0);
    chk({32'h0, irq}, 33'h0);
    wr(OFS_MASK, 32'h1);
    rd(OFS_STAT, 33'h1);
    wr(OFS_STAT, 32'h1);
    rd(OFS_STAT, 33'h0);
    chk({32'h0, irq}, 33'h0);
    wr(OFS_CNT_AL, 32'h0);
    idle_mode <= 1'h1;
    wr(OFS_CTRL_AL, 32'hA000);
    wr(OFS_PER_AH, 32'h3);
    wr(OFS_CTRL_AH, 32'h8040);
    repeat (10) @(posedge clk);
    rd(OFS_CNT_AL, 33'h0);
    rd(OFS_CNT_AH, 33'h0);
    gate_in <= 4'h2;
    tb_sel <= 1'h1;
    wrap(16'h3);
    chk({32'h0, trig_cnt != 0}, 33'h1);
    wr(OFS_CTRL_AH, 32'h0);
    wr(OFS_CTRL_AL, 32'h0);
    idle_mode <= 1'h0;
    trig_base = trig_cnt;
    wr(OFS_STAT, 32'hF);
    wr(OFS_CNT_BL, 32'hFFFF);
    wr(OFS_PER_BL, 32'h1);
    wr(OFS_PER_BH, 32'h1);
    wr(OFS_MASK, 32'h8);
    wr(OFS_CTRL_BL, 32'h8008);
    wr(OFS_CTRL_BH, 32'h8000);
    repeat (6) @(posedge clk);
    wr(OFS_CTRL_BH, 32'h0);
    wr(OFS_CTRL_BL, 32'h0);
    rd(OFS_CNT_BH, 33'h0);
    rd(OFS_STAT, 33'h8);
    chk({32'h0, irq}, 33'h1);
    wr(OFS_STAT, 32'hF);
    wr(OFS_CTRL_BH, 32'h8012);
    pulses(8);
    rd(OFS_CNT_BH, 33'h1);
    pulses(8);
    rd(OFS_CNT_BH, 33'h0);
    rd(OFS_STAT, 33'h8);
    sleep_mode <= 1'h1;
    pulses(8);
    rd(OFS_CNT_BH, 33'h0);
    wr(OFS_CTRL_BH, 32'h9012);
    pulses(8);
    rd(OFS_CNT_BH, 33'h1);
    chk({1'h0, 32'(trig_cnt)}, {1'h0, 32'(trig_base)});
    wr(OFS_CTRL_BH, 32'h0);
    sleep_mode <= 1'h0;
    wr(OFS_CNT_AL, 32'h0);
    wr(OFS_CTRL_AL, 32'h8020);
    repeat (100) @(posedge clk);
    rd(OFS_CNT_AL, 33'h1);
    wr(OFS_CTRL_AL, 32'h0);
    wr(OFS_CTRL_AL, 32'h8030);
    repeat (300) @(posedge clk);
    rd(OFS_CNT_AL, 33'h2);
    summarize();
  end
  initial begin
    #100000;
    miscompares++;
    summarize();
  end
endmodule
